// >>> verilog/pot_pkg.sv
`default_nettype none
package pot_pkg;
    localparam int POT_LANES = 4;
    localparam int POT_ADDR_W = 8;
    localparam int POT_DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] POT_ADDR_CTRL = 8'h00;
    localparam logic [7:0] POT_ADDR_STATUS = 8'h04;
    localparam logic [7:0] POT_ADDR_INT_STAT = 8'h08;
    localparam logic [7:0] POT_ADDR_INT_MASK = 8'h0C;
    localparam logic [7:0] POT_ADDR_FAULT_CAUSE = 8'h10;
    localparam logic [7:0] POT_ADDR_LOSS_CAUSE = 8'h14;
    localparam logic [7:0] POT_ADDR_FAULT_COUNT = 8'h18;

    // control fields
    localparam int POT_CTRL_FORCE_OFF = 0;
    localparam int POT_CTRL_CAUSE_CLR = 1;
    localparam int POT_CTRL_W = 2;
    localparam logic [1:0] POT_CTRL_RST = 2'h0;

    // status fields
    localparam int POT_ST_LASER_ON = 0;
    localparam int POT_ST_FAULT = 1;
    localparam int POT_ST_SIG_VALID = 2;
    localparam int POT_ST_DISABLE_PIN = 3;
    localparam int POT_ST_ENABLE_PIN = 4;
    localparam int POT_ST_RESET_PIN = 5;
    localparam int POT_ST_LOS_LSB = 8;

    // interrupt fields
    localparam int POT_INT_FAULT = 0;
    localparam int POT_INT_LOST = 1;
    localparam int POT_INT_GAINED = 2;
    localparam int POT_INT_W = 3;
    localparam logic [2:0] POT_INT_RST = 3'h0;

    localparam logic [1:0] POT_RESP_OKAY = 2'h0;
    localparam logic [1:0] POT_RESP_SLVERR = 2'h2;
    localparam logic [7:0] POT_FAULT_COUNT_RST = 8'h00;

    typedef struct packed {
        logic [3:0] over_current;
        logic over_temp;
        logic cal_corrupt;
    } pot_fault_src_s;

    localparam int POT_CAUSE_W = 6;

    typedef enum logic [1:0] {
        POT_TX_RUN = 2'b00,
        POT_TX_FAULT = 2'b01
    } pot_tx_state_e;

    // high only when no lane reports loss of signal
    function automatic logic pot_all_valid(input logic [3:0] los);
        return ~|los;
    endfunction
endpackage
`default_nettype wire

// >>> verilog/pot_fault_latch.sv
`timescale 1ns/100ps
`default_nettype none
module pot_fault_latch (
    input wire logic clk,                              // system clock
    input wire logic rst_b,                            // async reset
    input wire logic tx_reset_b_in,                    // transmitter reset pin
    input wire logic tx_enable_in,                     // transmit enable pin
    input wire pot_pkg::pot_fault_src_s fault_src,     // fault causes
    output var logic fault_latched,                    // fault held
    output var logic fault_rise                        // one-cycle new fault
);
    import pot_pkg::*;

    pot_tx_state_e state_reg;
    pot_tx_state_e state_next;
    logic enable_prev_reg;
    logic cause_any;
    logic clear_req;

    assign cause_any = (|fault_src.over_current) | fault_src.over_temp | fault_src.cal_corrupt;
    // reset pulse clears; enable rising edge clears
    assign clear_req = ~tx_reset_b_in | (tx_enable_in & ~enable_prev_reg);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            POT_TX_RUN: begin
                // held in reset only a live cause may latch
                if (cause_any) begin
                    state_next = POT_TX_FAULT;
                end
            end
            POT_TX_FAULT: begin
                // clears only once cause is gone
                if (clear_req && !cause_any) begin
                    state_next = POT_TX_RUN;
                end
            end
            default: begin
                state_next = POT_TX_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= POT_TX_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enable_prev_reg <= 1'b1;
        end else begin
            enable_prev_reg <= tx_enable_in;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_rise <= 1'b0;
        end else begin
            fault_rise <= (state_reg == POT_TX_RUN) && (state_next == POT_TX_FAULT);
        end
    end

    assign fault_latched = (state_reg == POT_TX_FAULT);
endmodule // pot_fault_latch
`default_nettype wire

// >>> verilog/pot_rx_detect.sv
`timescale 1ns/100ps
`default_nettype none
module pot_rx_detect #(
    parameter int LANES = 4
) (
    input wire logic clk,                       // system clock
    input wire logic rst_b,                     // async reset
    input wire logic [LANES-1:0] rx_los_in,     // per-lane loss of signal
    input wire logic [LANES-1:0] rx_data_in,    // receive data
    output var logic sig_valid_reg,             // all lanes valid
    output var logic [LANES-1:0] rx_data_reg    // squelched data
);
    import pot_pkg::*;

    logic sig_valid_next;

    // all four lanes must be good
    assign sig_valid_next = pot_all_valid(rx_los_in);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sig_valid_reg <= 1'b0;
        end else begin
            sig_valid_reg <= sig_valid_next;
        end
    end

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    rx_data_reg[g] <= 1'b0;
                end else begin
                    rx_data_reg[g] <= rx_data_in[g] & sig_valid_next;
                end
            end
        end
    endgenerate
endmodule // pot_rx_detect
`default_nettype wire

// >>> verilog/pot_ctrl.sv
// How it works
// - A high disable input turns every laser off, a low one allows light.
// - Lasers may be on only while the enable input is high.
// - A low transmitter reset input resets the transmitter logic and keeps lasers off.
// - The active-low fault output is high in normal operation and low on a fault.
// - Over-current on any laser, over-temperature or bad calibration data raises a fault.
// - A fault turns off the whole array and holds, once its cause is gone, until a reset pulse or an enable rising edge clears it.
// - Signal valid is high only when all receive lanes 0 to 3 have good input.
// - Loss of signal on any lane drops signal valid, and every lane is watched.
// - Receive data outputs are squelched while signal valid is low.
// - Disable and enable are separate gates: the lasers need disable low and enable high together.
`timescale 1ns/100ps
`default_nettype none
module pot_ctrl #(
    parameter int LANES = 4
) (
    input wire logic clk,                               // 25 MHz clock
    input wire logic rst_b,                             // async reset
    input wire logic [7:0] s_axi_awaddr,                // write address
    input wire logic s_axi_awvalid,                     // write address valid
    output var logic s_axi_awready,                     // write address ready
    input wire logic [31:0] s_axi_wdata,                // write data
    input wire logic [3:0] s_axi_wstrb,                 // write strobes
    input wire logic s_axi_wvalid,                      // write data valid
    output var logic s_axi_wready,                      // write data ready
    output var logic [1:0] s_axi_bresp,                 // write response
    output var logic s_axi_bvalid,                      // write response valid
    input wire logic s_axi_bready,                      // write response ready
    input wire logic [7:0] s_axi_araddr,                // read address
    input wire logic s_axi_arvalid,                     // read address valid
    output var logic s_axi_arready,                     // read address ready
    output var logic [31:0] s_axi_rdata,                // read data
    output var logic [1:0] s_axi_rresp,                 // read response
    output var logic s_axi_rvalid,                      // read data valid
    input wire logic s_axi_rready,                      // read data ready
    input wire logic laser_disable_in,                  // laser disable pin
    input wire logic tx_enable_in,                      // transmit enable pin
    input wire logic tx_reset_b_in,                     // transmitter reset pin
    input wire pot_pkg::pot_fault_src_s fault_src,      // fault causes
    input wire logic [LANES-1:0] rx_los_in,             // per-lane loss of signal
    input wire logic [LANES-1:0] rx_data_in,            // receive data
    output var logic [LANES-1:0] laser_on_out,          // laser drive enables
    output var logic tx_fault_b_out,                    // fault, active low
    output var logic rx_signal_valid_out,               // all lanes valid
    output var logic [LANES-1:0] rx_data_out,           // squelched receive data
    output var logic irq_out                            // interrupt level
);
    import pot_pkg::*;

    logic [POT_CTRL_W-1:0] ctrl_reg;
    logic [POT_INT_W-1:0] int_stat_reg;
    logic [POT_INT_W-1:0] int_mask_reg;
    logic [POT_CAUSE_W-1:0] fault_cause_reg;
    logic [LANES-1:0] loss_cause_reg;
    logic [7:0] fault_count_reg;
    logic sig_valid_prev_reg;
    logic [7:0] aw_addr_reg;
    logic aw_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic w_held_reg;
    logic fault_latched;
    logic fault_rise;
    logic sig_valid;
    logic laser_next;
    logic wr_fire;
    logic wr_hit;
    logic [POT_INT_W-1:0] int_set;
    logic [POT_INT_W-1:0] int_w1c;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [31:0] status_word;

    pot_fault_latch u_fault (
        .clk(clk),
        .rst_b(rst_b),
        .tx_reset_b_in(tx_reset_b_in),
        .tx_enable_in(tx_enable_in),
        .fault_src(fault_src),
        .fault_latched(fault_latched),
        .fault_rise(fault_rise)
    );

    pot_rx_detect #(.LANES(LANES)) u_rx (
        .clk(clk),
        .rst_b(rst_b),
        .rx_los_in(rx_los_in),
        .rx_data_in(rx_data_in),
        .sig_valid_reg(sig_valid),
        .rx_data_reg(rx_data_out)
    );

    // valid flag straight from its flop
    assign rx_signal_valid_out = sig_valid;

    // light only when all gates agree
    // reset pin and fault force off
    assign laser_next = ~laser_disable_in & tx_enable_in & tx_reset_b_in & ~fault_latched
                        & ~ctrl_reg[POT_CTRL_FORCE_OFF];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            laser_on_out <= '0;
        end else begin
            laser_on_out <= {LANES{laser_next}};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_fault_b_out <= 1'b1;
        end else begin
            tx_fault_b_out <= ~fault_latched;
        end
    end

    // write channel capture, either order
    // ready flops are the inverse of the held flags
    assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_held_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid && !aw_held_reg) begin
            aw_held_reg <= 1'b1;
            s_axi_awready <= 1'b0;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            w_held_reg <= 1'b0;
            s_axi_wready <= 1'b1;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && !w_held_reg) begin
            w_held_reg <= 1'b1;
            s_axi_wready <= 1'b0;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    always_comb begin
        case (aw_addr_reg)
            POT_ADDR_CTRL, POT_ADDR_STATUS, POT_ADDR_INT_STAT, POT_ADDR_INT_MASK,
            POT_ADDR_FAULT_CAUSE, POT_ADDR_LOSS_CAUSE, POT_ADDR_FAULT_COUNT: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= POT_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? POT_RESP_OKAY : POT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control register, low byte only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= POT_CTRL_RST;
        end else if (wr_fire && w_strb_reg[0] && aw_addr_reg == POT_ADDR_CTRL) begin
            ctrl_reg <= w_data_reg[POT_CTRL_W-1:0];
        end else begin
            ctrl_reg[POT_CTRL_CAUSE_CLR] <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            int_mask_reg <= POT_INT_RST;
        end else if (wr_fire && w_strb_reg[0] && aw_addr_reg == POT_ADDR_INT_MASK) begin
            int_mask_reg <= w_data_reg[POT_INT_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sig_valid_prev_reg <= 1'b0;
        end else begin
            sig_valid_prev_reg <= sig_valid;
        end
    end

    assign int_set[POT_INT_FAULT] = fault_rise;
    assign int_set[POT_INT_LOST] = sig_valid_prev_reg & ~sig_valid;
    assign int_set[POT_INT_GAINED] = ~sig_valid_prev_reg & sig_valid;
    assign int_w1c = (wr_fire && w_strb_reg[0] && aw_addr_reg == POT_ADDR_INT_STAT)
                     ? w_data_reg[POT_INT_W-1:0] : '0;

    // set wins over write-one clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            int_stat_reg <= POT_INT_RST;
        end else begin
            int_stat_reg <= (int_stat_reg & ~int_w1c) | int_set;
        end
    end

    // level interrupt, one cycle behind status
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(int_stat_reg & int_mask_reg);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_cause_reg <= '0;
        end else if (ctrl_reg[POT_CTRL_CAUSE_CLR]) begin
            fault_cause_reg <= fault_src;
        end else begin
            fault_cause_reg <= fault_cause_reg | fault_src;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            loss_cause_reg <= '0;
        end else if (ctrl_reg[POT_CTRL_CAUSE_CLR]) begin
            loss_cause_reg <= rx_los_in;
        end else begin
            loss_cause_reg <= loss_cause_reg | rx_los_in;
        end
    end

    // saturating count of fault entries
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_count_reg <= POT_FAULT_COUNT_RST;
        end else if (fault_rise && fault_count_reg != 8'hFF) begin
            fault_count_reg <= fault_count_reg + 8'h01;
        end
    end

    // read-only status word
    always_comb begin
        status_word = 32'h00000000;
        status_word[POT_ST_LASER_ON] = laser_on_out[0];
        status_word[POT_ST_FAULT] = fault_latched;
        status_word[POT_ST_SIG_VALID] = sig_valid;
        status_word[POT_ST_DISABLE_PIN] = laser_disable_in;
        status_word[POT_ST_ENABLE_PIN] = tx_enable_in;
        status_word[POT_ST_RESET_PIN] = tx_reset_b_in;
        status_word[POT_ST_LOS_LSB +: LANES] = rx_los_in;
    end

    // read decode
    always_comb begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            POT_ADDR_CTRL: rd_word[POT_CTRL_W-1:0] = ctrl_reg;
            POT_ADDR_STATUS: rd_word = status_word;
            POT_ADDR_INT_STAT: rd_word[POT_INT_W-1:0] = int_stat_reg;
            POT_ADDR_INT_MASK: rd_word[POT_INT_W-1:0] = int_mask_reg;
            POT_ADDR_FAULT_CAUSE: rd_word[POT_CAUSE_W-1:0] = fault_cause_reg;
            POT_ADDR_LOSS_CAUSE: rd_word[LANES-1:0] = loss_cause_reg;
            POT_ADDR_FAULT_COUNT: rd_word[7:0] = fault_count_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    // read channel, arready low while rvalid stands

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= POT_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? POT_RESP_OKAY : POT_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // pot_ctrl
`default_nettype wire

// >>> tb/pot_ctrl_chk.sv
`timescale 1ns/100ps
`default_nettype none
module pot_ctrl_chk #(
    parameter int LANES = 4
) (
    input wire logic clk,                          // clock
    input wire logic rst_b,                        // reset
    input wire logic laser_disable_in,             // disable pin
    input wire logic tx_enable_in,                 // enable pin
    input wire logic tx_reset_b_in,                // tx reset pin
    input wire pot_pkg::pot_fault_src_s fault_src, // fault causes
    input wire logic [LANES-1:0] rx_los_in,        // lane loss
    input wire logic [LANES-1:0] rx_data_in,       // rx data in
    input wire logic [LANES-1:0] laser_on_out,     // laser drive
    input wire logic tx_fault_b_out,               // fault pin
    input wire logic rx_signal_valid_out,          // signal valid
    input wire logic [LANES-1:0] rx_data_out       // rx data out
);
    import pot_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_cause;
        |fault_src;
    endsequence
    sequence s_fault_ends;
        !tx_fault_b_out ##1 tx_fault_b_out;
    endsequence
    property p_dis_off;
        laser_disable_in |=> laser_on_out == '0;
    endproperty
    property p_en_off;
        !tx_enable_in |=> laser_on_out == '0;
    endproperty
    property p_rst_off;
        !tx_reset_b_in |=> laser_on_out == '0;
    endproperty
    property p_fault_off;
        !tx_fault_b_out |-> laser_on_out == '0;
    endproperty
    property p_gates;
        laser_on_out != '0 |-> laser_on_out == '1 && tx_fault_b_out && !$past(laser_disable_in)
            && $past(tx_enable_in) && $past(tx_reset_b_in);
    endproperty
    property p_cause;
        s_cause |-> ##2 !tx_fault_b_out;
    endproperty
    property p_clear;
        s_fault_ends |-> !$past(tx_reset_b_in, 2)
            || ($past(tx_enable_in, 2) && !$past(tx_enable_in, 3));
    endproperty
    property p_sig;
        $past(rst_b) |-> rx_signal_valid_out == ~|$past(rx_los_in);
    endproperty
    property p_squelch;
        !rx_signal_valid_out |-> rx_data_out == '0;
    endproperty
    property p_pass;
        rx_signal_valid_out |-> rx_data_out == $past(rx_data_in);
    endproperty
    a_dis_off: assert property (p_dis_off) else $error("laser on while disabled");
    a_en_off: assert property (p_en_off) else $error("laser on while not enabled");
    a_rst_off: assert property (p_rst_off) else $error("laser on during tx reset");
    a_fault_off: assert property (p_fault_off) else $error("laser on during fault");
    a_gates: assert property (p_gates) else $error("laser on without all gates");
    a_cause: assert property (p_cause) else $error("fault not raised");
    a_clear: assert property (p_clear) else $error("fault cleared without request");
    a_sig: assert property (p_sig) else $error("signal valid wrong");
    a_squelch: assert property (p_squelch) else $error("rx data not squelched");
    a_pass: assert property (p_pass) else $error("rx data not passed");
endmodule // pot_ctrl_chk
`default_nettype wire

// >>> tb/pot_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module pot_host_model (
    input wire logic clk,              // clock
    output var logic laser_disable_in, // disable pin
    output var logic tx_enable_in,     // enable pin
    output var logic tx_reset_b_in     // tx reset pin
);
    initial begin
        laser_disable_in = 1'b0;
        tx_enable_in = 1'b1;
        tx_reset_b_in = 1'b1;
    end
    task automatic set_pins(input logic dis, input logic en, input logic rb);
        laser_disable_in <= dis;
        tx_enable_in <= en;
        tx_reset_b_in <= rb;
    endtask
    task automatic pulse_reset(input int w);
        tx_reset_b_in <= 1'b0;
        repeat (w) @(posedge clk);
        tx_reset_b_in <= 1'b1;
    endtask
    task automatic toggle_enable(input int w);
        tx_enable_in <= 1'b0;
        repeat (w) @(posedge clk);
        tx_enable_in <= 1'b1;
    endtask
endmodule // pot_host_model
`default_nettype wire

// >>> tb/pot_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pot_ctrl_tb_top;
    import pot_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, tx_fault_b_out, rx_signal_valid_out, irq_out;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic laser_disable_in, tx_enable_in, tx_reset_b_in;
    pot_fault_src_s fault_src = '0;
    logic [3:0] rx_los_in = 4'h0, rx_data_in = 4'h0, laser_on_out, rx_data_out;
    int mismatches = 0;
    int num_checks = 0;

    always #20 clk = ~clk;

    pot_host_model u_host (.clk, .laser_disable_in, .tx_enable_in, .tx_reset_b_in);
    pot_ctrl #(.LANES(4)) u_dut (
        .clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .laser_disable_in, .tx_enable_in,
        .tx_reset_b_in, .fault_src, .rx_los_in, .rx_data_in, .laser_on_out,
        .tx_fault_b_out, .rx_signal_valid_out, .rx_data_out, .irq_out
    );

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rready && s_axi_rvalid) begin
                v = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end while (s_axi_arvalid || s_axi_rready);
    endtask

    initial begin
        #(40 * 5000);
        mismatches++;
        stop_test();
    end

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] zr[3] = '{POT_ADDR_CTRL, POT_ADDR_INT_MASK, POT_ADDR_FAULT_COUNT};
        cyc(8);
        chk(32'({laser_on_out, tx_fault_b_out, rx_signal_valid_out, irq_out}), 32'h4);
        rst_b <= 1'b1;
        cyc(2);
        foreach (zr[k]) begin
            axi_read(zr[k], d, r);
            chk(d, 32'h0);
        end
        for (int i = 0; i < 8; i++) begin
            u_host.set_pins(i[2], i[1], i[0]);
            cyc(3);
            chk(32'(laser_on_out), (i == 3) ? 32'hF : 32'h0);
        end
        u_host.set_pins(1'b0, 1'b1, 1'b1);
        rx_data_in <= 4'hA;
        for (int l = 0; l < 4; l++) begin
            rx_los_in <= 4'h1 << l;
            cyc(3);
            chk(32'({rx_signal_valid_out, rx_data_out}), 32'h0);
            rx_los_in <= 4'h0;
            cyc(3);
            chk(32'({rx_signal_valid_out, rx_data_out}), 32'h1A);
        end
        for (int f = 0; f < 6; f++) begin
            fault_src <= pot_fault_src_s'(6'h1 << f);
            cyc(3);
            u_host.pulse_reset(1);
            cyc(3);
            chk(32'({tx_fault_b_out, laser_on_out}), 32'h0);
            fault_src <= '0;
            cyc(1);
            if (f[0]) u_host.toggle_enable(2);
            else u_host.pulse_reset(2);
            cyc(3);
            chk(32'({tx_fault_b_out, laser_on_out}), 32'h1F);
        end
        axi_read(POT_ADDR_FAULT_COUNT, d, r);
        chk(d, 32'h6);
        axi_read(POT_ADDR_FAULT_CAUSE, d, r);
        chk(d, 32'h3F);
        axi_read(POT_ADDR_LOSS_CAUSE, d, r);
        chk(d, 32'hF);
        axi_write(POT_ADDR_STATUS, 32'h0, r);
        chk(32'(r), 32'(POT_RESP_OKAY));
        axi_read(POT_ADDR_STATUS, d, r);
        chk(d, 32'h35);
        axi_write(8'h20, 32'h0, r);
        chk(32'(r), 32'(POT_RESP_SLVERR));
        axi_read(8'h20, d, r);
        chk({d[29:0], r}, 32'(POT_RESP_SLVERR));
        axi_write(POT_ADDR_CTRL, 32'h1, r);
        cyc(2);
        chk(32'(laser_on_out), 32'h0);
        axi_read(POT_ADDR_CTRL, d, r);
        chk(d, 32'h1);
        axi_write(POT_ADDR_CTRL, 32'h0, r);
        axi_write(POT_ADDR_CTRL, 32'h2, r);
        axi_read(POT_ADDR_FAULT_CAUSE, d, r);
        chk(d, 32'h0);
        axi_read(POT_ADDR_LOSS_CAUSE, d, r);
        chk(d, 32'h0);
        axi_read(POT_ADDR_CTRL, d, r);
        chk(d, 32'h0);
        axi_read(POT_ADDR_INT_STAT, d, r);
        chk({d[30:0], irq_out}, 32'hE);
        axi_write(POT_ADDR_INT_MASK, 32'h2, r);
        cyc(2);
        chk(32'(irq_out), 32'h1);
        axi_write(POT_ADDR_INT_STAT, 32'h2, r);
        cyc(2);
        chk(32'(irq_out), 32'h0);
        axi_read(POT_ADDR_INT_STAT, d, r);
        chk(d, 32'h5);
        stop_test();
    end
endmodule // pot_ctrl_tb_top

bind pot_ctrl pot_ctrl_chk #(.LANES(LANES)) u_chk (
    .clk, .rst_b, .laser_disable_in, .tx_enable_in, .tx_reset_b_in, .fault_src,
    .rx_los_in, .rx_data_in, .laser_on_out, .tx_fault_b_out, .rx_signal_valid_out,
    .rx_data_out
);
`default_nettype wire
